// >>> bench/mtch_adc_model.sv
// converter stand-in answering each request after a short or long wait
// assumes requests are held until acked, all on core_clk
`timescale 1ns/10ps
module mtch_adc_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request side
    input wire logic adcReq,
    input wire logic [4:0] adcChan,
    input wire logic slow,
    // answer side
    output logic adcAck,
    output logic [15:0] adcData,
    output logic adcOpen,
    output logic adcBack
);
    logic [2:0] waitCnt;
    // outside the ack cycle the lines invert every cycle, so every second cycle they carry the last value again
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitCnt <= 3'h0;
            adcAck <= 1'b0;
            adcData <= 16'h0000;
            adcOpen <= 1'b0;
            adcBack <= 1'b0;
        end
        else if (adcReq && !adcAck && waitCnt == (slow ? 3'h3 : 3'h0))
        begin
            waitCnt <= 3'h0;
            adcAck <= 1'b1;
            adcData <= {adcChan, 3'h5, adcChan, 3'h2};
            adcOpen <= adcChan[0];
            adcBack <= adcChan[1];
        end
        else
        begin
            waitCnt <= (adcReq && !adcAck) ? waitCnt + 3'h1 : 3'h0;
            adcAck <= 1'b0;
            adcData <= ~adcData;
            adcOpen <= ~adcOpen;
            adcBack <= ~adcBack;
        end
    end
endmodule

// >>> bench/mtch_handshake_asserts.sv
// port-level checks for the thermocouple handshake block
// assumes one core clock and an active-low asynchronous reset
`timescale 1ns/10ps
module mtch_handshake_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // cyclic bytes
    input wire logic ctrlValid,
    input wire logic [7:0] ctrlByte,
    input wire logic [7:0] statusByte,
    input wire logic [mtch_pkg::IN_W-1:0] inputData,
    // configuration
    input wire logic cfgWrDone,
    input wire logic cfgApplying,
    input wire logic [mtch_pkg::NUM_CH-1:0] chanActive,
    input wire logic nvmWrite,
    input wire logic [mtch_pkg::CFG_W-1:0] nvmWrData,
    // converter and measuring
    input wire logic adcReq,
    input wire logic [mtch_pkg::CH_IDX_W-1:0] adcChan,
    input wire logic adcAck,
    input wire logic measBusy
);
    logic [mtch_pkg::NUM_CH-1:0] cfgLive;
    // live only when both field bits are clear
    always_comb
    begin
        for (int i = 0; i < mtch_pkg::NUM_CH; i++)
            cfgLive[i] = (nvmWrData[2*i+:2] == 2'h0);
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // request taken, answer two edges on
    sequence selTaken;
        ctrlValid ##2 1'b1;
    endsequence
    // commit pulse, mask one edge later
    sequence commitSeen;
        nvmWrite ##1 1'b1;
    endsequence
    a_status_echo: assert property (selTaken
        |-> statusByte[3:0] == $past(ctrlByte[3:0], 2))
        else $error("status select does not echo the request");
    a_rsvd_zero: assert property (statusByte[6:4] == 3'h0)
        else $error("reserved status bits not zero");
    a_unsel_zero: assert property ((statusByte[3:0] == 4'h0 || statusByte[3:0] > 4'h9)
        |-> inputData == '0)
        else $error("data present for an empty selection");
    a_apply_zero: assert property (cfgApplying && $past(cfgApplying)
        |-> inputData == '0)
        else $error("data not forced to zero while applying");
    a_commit_mask: assert property (commitSeen |-> chanActive == cfgLive && !cfgApplying)
        else $error("active mask differs from stored fields");
    a_nvm_cause: assert property (nvmWrite |-> $past(cfgWrDone))
        else $error("store pulse without a finished write");
    a_done_only: assert property ($changed(statusByte[7]) |-> $fell(measBusy))
        else $error("done toggle moved outside cycle end");
    a_done_flip: assert property ($fell(measBusy)
        |-> statusByte[7] != $past(statusByte[7]))
        else $error("cycle ended without done toggle");
    a_adc_hold: assert property (adcReq && !adcAck |=> adcReq && $stable(adcChan))
        else $error("conversion request dropped before ack");
    a_adc_busy: assert property (adcReq |-> measBusy)
        else $error("conversion request outside a cycle");
endmodule
bind mtch_handshake mtch_handshake_asserts u_asserts (.core_clk(core_clk), .rst_n(rst_n),
    .ctrlValid(ctrlValid), .ctrlByte(ctrlByte), .statusByte(statusByte),
    .inputData(inputData), .cfgWrDone(cfgWrDone), .cfgApplying(cfgApplying),
    .chanActive(chanActive), .nvmWrite(nvmWrite), .nvmWrData(nvmWrData), .adcReq(adcReq),
    .adcChan(adcChan), .adcAck(adcAck), .measBusy(measBusy));

// >>> bench/tb_mtch_handshake.sv
// self-checking bench acting as the fieldbus master of the handshake block
// assumes the converter model above; config storage driven directly
`timescale 1ns/10ps
module tb_mtch_handshake;
    logic core_clk, rst_n, ctrlValid, bigEndian, cfgWrValid, cfgWrDone, nvmLoadValid, slow;
    logic [7:0] ctrlByte, statusByte, cfgWrByte;
    logic [3:0] cfgWrIdx;
    logic [63:0] inputData, nvmLoadData, nvmWrData, expCfg;
    logic [31:0] chanActive, measAct;
    logic cfgApplying, nvmWrite, adcReq, adcAck, adcOpen, adcBack, measBusy, tog;
    logic [4:0] adcChan;
    logic [15:0] adcData;
    int mismatches, compares;

    mtch_handshake DUT (.core_clk(core_clk), .rst_n(rst_n), .ctrlValid(ctrlValid),
        .ctrlByte(ctrlByte), .statusByte(statusByte), .inputData(inputData),
        .bigEndian(bigEndian), .cfgWrValid(cfgWrValid), .cfgWrIdx(cfgWrIdx),
        .cfgWrByte(cfgWrByte), .cfgWrDone(cfgWrDone), .cfgApplying(cfgApplying),
        .chanActive(chanActive), .nvmLoadValid(nvmLoadValid), .nvmLoadData(nvmLoadData),
        .nvmWrite(nvmWrite), .nvmWrData(nvmWrData), .adcReq(adcReq), .adcChan(adcChan),
        .adcAck(adcAck), .adcData(adcData), .adcOpen(adcOpen), .adcBack(adcBack),
        .measBusy(measBusy));
    mtch_adc_model u_adc (.core_clk(core_clk), .rst_n(rst_n), .adcReq(adcReq),
        .adcChan(adcChan), .slow(slow), .adcAck(adcAck), .adcData(adcData),
        .adcOpen(adcOpen), .adcBack(adcBack));

    // 40 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // wide enough for the joined status, mask and data words
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // two field bits per channel, lowest channel in the low pair
    function automatic logic [31:0] actOf(input logic [63:0] c);
        for (int i = 0; i < 32; i++)
            actOf[i] = (c[2*i+:2] == 2'h0);
    endfunction

    // expected input bytes for a selection, from the last measured mask
    function automatic logic [63:0] expGroup(input logic [3:0] code);
        logic [63:0] r;
        logic [15:0] v;
        logic [4:0] n;
        r = 64'h0;
        for (int i = 0; i < 32; i++)
        begin
            n = i[4:0];
            if (code == 4'h9)
                r[i] = measAct[i] & n[0];
            if (code == 4'h9)
                r[32+i] = measAct[i] & n[1];
        end
        for (int k = 0; k < 4 && code >= 4'h1 && code <= 4'h8; k++)
        begin
            n = 5'((code - 4'h1) * 4 + k);
            v = measAct[n] ? {n, 3'h5, n, 3'h2} : 16'h0000;
            r[16*k+:16] = bigEndian ? {v[7:0], v[15:8]} : v;
        end
        return r;
    endfunction

    // reserved bits set on purpose; they must be ignored
    task automatic select(input logic [3:0] code);
        @(posedge core_clk);
        ctrlValid <= 1'b1;
        ctrlByte <= {tog, 3'h7, code};
        @(posedge core_clk);
        ctrlValid <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check(statusByte, {tog, 3'h0, code});
        check(inputData, expGroup(code));
    endtask

    task automatic measure(input logic spd);
        int n;
        measAct = actOf(expCfg);
        tog = ~tog;
        @(posedge core_clk);
        slow <= spd;
        ctrlValid <= 1'b1;
        ctrlByte <= {tog, 3'h0, 4'h0};
        @(posedge core_clk);
        ctrlValid <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check(measBusy, 1'b1);
        n = 0;
        while (statusByte[7] !== tog && n < 3000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(statusByte[7], tog);
        // a cycle that never ends has been counted; stop here
        if (statusByte[7] !== tog)
            complete_run();
        $display("test measure done");
    endtask

    task automatic cfgByte(input logic [3:0] idx, input logic [7:0] b);
        @(posedge core_clk);
        cfgWrValid <= 1'b1;
        cfgWrIdx <= idx;
        cfgWrByte <= b;
        expCfg[8*idx+:8] = b;
    endtask

    // fixed edges: store pulse one edge after done, mask one edge after that
    task automatic cfgCommit();
        @(posedge core_clk);
        cfgWrValid <= 1'b0;
        cfgWrDone <= 1'b1;
        @(posedge core_clk);
        cfgWrDone <= 1'b0;
        #1;
        check({nvmWrite, cfgApplying, nvmWrData}, {2'h3, expCfg});
        check(inputData, 64'h0);
        @(posedge core_clk);
        #1;
        check({cfgApplying, chanActive}, {1'b0, actOf(expCfg)});
        $display("test config write done");
    endtask

    initial
    begin
        {rst_n, ctrlValid, bigEndian, cfgWrValid, cfgWrDone, nvmLoadValid, slow, tog} = '0;
        {ctrlByte, cfgWrByte, cfgWrIdx, nvmLoadData, expCfg} = '0;
        mismatches = 0;
        compares = 0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check({statusByte, chanActive, inputData}, {8'h00, 32'hFFFF_FFFF, 64'h0});
        // a lone done without bytes must be ignored
        @(posedge core_clk);
        cfgWrDone <= 1'b1;
        @(posedge core_clk);
        cfgWrDone <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check({cfgApplying, chanActive}, {1'b0, 32'hFFFF_FFFF});
        $display("test reset done");
        measure(1'b0);
        for (int c = 0; c < 16; c++)
            select(c[3:0]);
        @(posedge core_clk);
        bigEndian <= 1'b1;
        for (int c = 1; c < 9; c++)
            select(c[3:0]);
        $display("test selection done");
        // two bytes back to back, channels 0, 3 and 29 off
        cfgByte(4'h0, 8'h81);
        cfgByte(4'h7, 8'h0C);
        cfgCommit();
        measure(1'b1);
        for (int c = 1; c < 10; c++)
            select(c[3:0]);
        // back-to-back selections, only the later one stands
        @(posedge core_clk);
        ctrlValid <= 1'b1;
        ctrlByte <= {tog, 3'h0, 4'h3};
        @(posedge core_clk);
        ctrlByte <= {tog, 3'h0, 4'h5};
        @(posedge core_clk);
        ctrlValid <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check({statusByte, inputData}, {tog, 7'h05, expGroup(4'h5)});
        cfgByte(4'h0, 8'h00);
        cfgCommit();
        // restore from storage, only channels 0 and 1 live
        @(posedge core_clk);
        nvmLoadValid <= 1'b1;
        nvmLoadData <= 64'hFFFF_FFFF_FFFF_FFF0;
        expCfg = 64'hFFFF_FFFF_FFFF_FFF0;
        @(posedge core_clk);
        nvmLoadValid <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check(chanActive, 32'h0000_0003);
        measure(1'b0);
        select(4'h1);
        select(4'h9);
        $display("test restore done");
        complete_run();
    end
endmodule

// >>> rtl/mtch_conv_if.sv
// carrier between the handshake controller and its conversion sequencer
// assumes both ends run on the same core clock
`timescale 1ns/10ps
interface mtch_conv_if;
    logic start;
    logic [mtch_pkg::NUM_CH-1:0] activeMask;
    logic done;
    logic wrEn;
    logic [mtch_pkg::CH_IDX_W-1:0] wrIdx;
    logic [mtch_pkg::CH_W-1:0] wrData;
    logic wrOpen;
    logic wrBack;

    modport ctl (output start, output activeMask, input done, input wrEn, input wrIdx,
        input wrData, input wrOpen, input wrBack);
    modport seq (input start, input activeMask, output done, output wrEn, output wrIdx,
        output wrData, output wrOpen, output wrBack);
endinterface

// >>> rtl/mtch_conv_seq.sv
// conversion sequencer: walks all channels once per measuring cycle
// assumes the converter answers each request with a one-cycle ack on core_clk
`timescale 1ns/10ps
module mtch_conv_seq (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // controller side
    mtch_conv_if.seq conv,
    // converter side
    output logic adcReq,
    output logic [mtch_pkg::CH_IDX_W-1:0] adcChan,
    input wire logic adcAck,
    input wire logic [mtch_pkg::CH_W-1:0] adcData,
    input wire logic adcOpen,
    input wire logic adcBack
);
    typedef struct packed {
        mtch_pkg::mtch_seq_t state;
        logic [mtch_pkg::NUM_CH-1:0] mask;
        logic [mtch_pkg::CH_IDX_W-1:0] idx;
        logic req;
        logic done;
        logic wrEn;
        logic [mtch_pkg::CH_W-1:0] wrData;
        logic wrOpen;
        logic wrBack;
    } mtch_seq_reg_t;

    mtch_seq_reg_t cur;
    mtch_seq_reg_t next_cur;

    // one pass over every channel; inactive ones get a zero result
    always_comb
    begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.wrEn = 1'b0;
        case (cur.state)
            mtch_pkg::SEQ_IDLE:
            begin
                if (conv.start)
                begin
                    next_cur.mask = conv.activeMask;
                    next_cur.idx = '0;
                    next_cur.state = mtch_pkg::SEQ_SCAN;
                end
            end
            mtch_pkg::SEQ_SCAN:
            begin
                if (cur.mask[cur.idx])
                begin
                    next_cur.req = 1'b1;
                    next_cur.state = mtch_pkg::SEQ_WAIT;
                end
                else
                begin
                    // no data for unassociated channels
                    next_cur.wrEn = 1'b1;
                    next_cur.wrData = '0;
                    next_cur.wrOpen = 1'b0;
                    next_cur.wrBack = 1'b0;
                    if (cur.idx == 5'h1F)
                        next_cur.state = mtch_pkg::SEQ_DONE;
                    else
                        next_cur.idx = cur.idx + 5'h01;
                end
            end
            mtch_pkg::SEQ_WAIT:
            begin
                if (adcAck)
                begin
                    next_cur.req = 1'b0;
                    next_cur.wrEn = 1'b1;
                    next_cur.wrData = adcData;
                    next_cur.wrOpen = adcOpen;
                    next_cur.wrBack = adcBack;
                    if (cur.idx == 5'h1F)
                        next_cur.state = mtch_pkg::SEQ_DONE;
                    else
                    begin
                        next_cur.idx = cur.idx + 5'h01;
                        next_cur.state = mtch_pkg::SEQ_SCAN;
                    end
                end
            end
            mtch_pkg::SEQ_DONE:
            begin
                next_cur.done = 1'b1;
                next_cur.state = mtch_pkg::SEQ_IDLE;
            end
            default:
                next_cur.state = mtch_pkg::SEQ_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur <= '{state: mtch_pkg::SEQ_IDLE, default: '0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // the result index lags idx by one, as idx has already stepped on; in the done state the write carries 31
    assign adcReq = cur.req;
    assign adcChan = cur.idx;
    assign conv.done = cur.done;
    assign conv.wrEn = cur.wrEn;
    assign conv.wrIdx = (cur.state == mtch_pkg::SEQ_DONE) ? 5'h1F : cur.idx - {4'h0, cur.wrEn};
    assign conv.wrData = cur.wrData;
    assign conv.wrOpen = cur.wrOpen;
    assign conv.wrBack = cur.wrBack;
endmodule

// >>> rtl/mtch_handshake.sv
// cyclic multiplex handshake and channel configuration for a 32 channel
// thermocouple input module
// assumes fieldbus, converter and storage logic all run on core_clk
`timescale 1ns/10ps
module mtch_handshake (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // cyclic process data
    input wire logic ctrlValid,
    input wire logic [7:0] ctrlByte,
    output logic [7:0] statusByte,
    output logic [mtch_pkg::IN_W-1:0] inputData,
    // configuration parameter
    input wire logic bigEndian,
    // acyclic channel configuration write
    input wire logic cfgWrValid,
    input wire logic [mtch_pkg::CFG_IDX_W-1:0] cfgWrIdx,
    input wire logic [7:0] cfgWrByte,
    input wire logic cfgWrDone,
    output logic cfgApplying,
    output logic [mtch_pkg::NUM_CH-1:0] chanActive,
    // non-volatile storage
    input wire logic nvmLoadValid,
    input wire logic [mtch_pkg::CFG_W-1:0] nvmLoadData,
    output logic nvmWrite,
    output logic [mtch_pkg::CFG_W-1:0] nvmWrData,
    // converter
    output logic adcReq,
    output logic [mtch_pkg::CH_IDX_W-1:0] adcChan,
    input wire logic adcAck,
    input wire logic [mtch_pkg::CH_W-1:0] adcData,
    input wire logic adcOpen,
    input wire logic adcBack,
    // measuring state
    output logic measBusy
);
    typedef struct packed {
        logic [mtch_pkg::CFG_W-1:0] chanCfg;
        logic [mtch_pkg::CFG_W-1:0] cfgShadow;
        logic applying;
        logic commitTail;
        logic nvmWrite;
        logic [mtch_pkg::NUM_CH-1:0] active;
        logic [3:0] reqSel;
        logic ctrlToggle;
        logic measBit;
        logic busy;
        logic start;
        logic [7:0] status;
        logic [mtch_pkg::IN_W-1:0] inData;
        logic [mtch_pkg::NUM_CH-1:0][mtch_pkg::CH_W-1:0] results;
        logic [mtch_pkg::NUM_CH-1:0] openFlags;
        logic [mtch_pkg::NUM_CH-1:0] backFlags;
    } mtch_top_reg_t;

    mtch_top_reg_t cur;
    mtch_top_reg_t next_cur;

    mtch_conv_if conv ();

    // conversion sequencer
    mtch_conv_seq u_seq (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .conv(conv),
        .adcReq(adcReq),
        .adcChan(adcChan),
        .adcAck(adcAck),
        .adcData(adcData),
        .adcOpen(adcOpen),
        .adcBack(adcBack)
    );

    assign conv.start = cur.start;
    assign conv.activeMask = cur.active;

    // decode the two-bit field of each channel into an active flag
    function automatic logic [mtch_pkg::NUM_CH-1:0] decodeActive(
        input logic [mtch_pkg::CFG_W-1:0] cfg
    );
        logic [mtch_pkg::NUM_CH-1:0] act;
        act = '0;
        for (int i = 0; i < mtch_pkg::NUM_CH; i++)
        begin
            act[i] = ~(cfg[2*i] | cfg[2*i+1]);
        end
        return act;
    endfunction

    // build the eight input bytes for a selection code
    function automatic logic [mtch_pkg::IN_W-1:0] buildData(
        input logic [3:0] sel,
        input logic swapOrder,
        input logic [mtch_pkg::NUM_CH-1:0] act,
        input logic [mtch_pkg::NUM_CH-1:0][mtch_pkg::CH_W-1:0] res,
        input logic [mtch_pkg::NUM_CH-1:0] oc,
        input logic [mtch_pkg::NUM_CH-1:0] bv
    );
        logic [mtch_pkg::IN_W-1:0] d;
        logic [2:0] grp;
        logic [mtch_pkg::CH_IDX_W-1:0] ch;
        logic [mtch_pkg::CH_W-1:0] word;
        d = '0;
        grp = 3'h0;
        ch = '0;
        word = '0;
        if (sel == mtch_pkg::SEL_FLAGS)
        begin
            // flag bit n of each half belongs to channel n
            d[31:0] = oc;
            d[63:32] = bv;
        end
        else if (sel != mtch_pkg::SEL_NONE && sel <= mtch_pkg::SEL_LAST_GROUP)
        begin
            grp = 3'(sel - 4'h1);
            for (int k = 0; k < mtch_pkg::CH_PER_GROUP; k++)
            begin
                ch = {grp, 2'(k)};
                word = act[ch] ? res[ch] : '0;
                if (swapOrder)
                    d[16*k +: 16] = {word[7:0], word[15:8]};
                else
                    d[16*k +: 16] = word;
            end
        end
        return d;
    endfunction

    // next-state logic
    always_comb
    begin
        next_cur = cur;
        next_cur.start = 1'b0;
        next_cur.nvmWrite = 1'b0;

        // storage image loaded after power-up replaces the reset set
        if (nvmLoadValid && !cur.applying)
        begin
            next_cur.chanCfg = nvmLoadData;
        end

        // acyclic write: stage bytes in a shadow so partial writes stay intact
        if (cfgWrValid)
        begin
            if (!cur.applying)
            begin
                next_cur.cfgShadow = cur.chanCfg;
                next_cur.cfgShadow[8*cfgWrIdx +: 8] = cfgWrByte;
            end
            else
            begin
                next_cur.cfgShadow[8*cfgWrIdx +: 8] = cfgWrByte;
            end
            next_cur.applying = 1'b1;
        end
        if (cfgWrDone && cur.applying)
        begin
            next_cur.chanCfg = next_cur.cfgShadow;
            next_cur.nvmWrite = 1'b1;
            next_cur.commitTail = 1'b1;
        end
        // hold the zeroed outputs one cycle past commit so active settles
        if (cur.commitTail)
        begin
            next_cur.commitTail = 1'b0;
            // a byte arriving in the clearing cycle wins and keeps the change open
            next_cur.applying = cfgWrValid;
        end

        next_cur.active = decodeActive(cur.chanCfg);

        // cyclic control byte: latch selection and toggle
        if (ctrlValid)
        begin
            next_cur.reqSel = ctrlByte[mtch_pkg::SEL_MSB:mtch_pkg::SEL_LSB];
            next_cur.ctrlToggle = ctrlByte[mtch_pkg::TOGGLE_BIT];
        end

        // a new measuring cycle waits for a running one and for config commit
        if (!cur.busy && !cur.applying && cur.ctrlToggle != cur.measBit)
        begin
            next_cur.measBit = cur.ctrlToggle;
            next_cur.busy = 1'b1;
            next_cur.start = 1'b1;
        end

        // results are held until the next cycle overwrites them
        if (conv.wrEn)
        begin
            next_cur.results[conv.wrIdx] = conv.wrData;
            next_cur.openFlags[conv.wrIdx] = conv.wrOpen;
            next_cur.backFlags[conv.wrIdx] = conv.wrBack;
        end
        if (conv.done)
        begin
            next_cur.busy = 1'b0;
            next_cur.status[mtch_pkg::TOGGLE_BIT] = cur.measBit;
        end

        // data and its confirmation land on the same edge
        if (cur.applying)
            next_cur.inData = '0;
        else
            next_cur.inData = buildData(cur.reqSel, bigEndian, cur.active, cur.results,
                cur.openFlags, cur.backFlags);
        next_cur.status[mtch_pkg::SEL_MSB:mtch_pkg::SEL_LSB] = cur.reqSel;
        next_cur.status[6:4] = mtch_pkg::RSVD_VALUE;
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur <= '0;
            cur.chanCfg <= mtch_pkg::CFG_RESET;
            cur.cfgShadow <= mtch_pkg::CFG_RESET;
            cur.status <= mtch_pkg::STATUS_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state register
    assign statusByte = cur.status;
    assign inputData = cur.inData;
    assign cfgApplying = cur.applying;
    assign chanActive = cur.active;
    assign nvmWrite = cur.nvmWrite;
    assign nvmWrData = cur.chanCfg;
    assign measBusy = cur.busy;
endmodule

// >>> rtl/mtch_pkg.sv
// constants shared by the thermocouple channel handshake block
// assumes a single core clock domain; nothing is imported, all uses are scoped
package mtch_pkg;
    // channel counts and widths
    localparam int NUM_CH = 32;
    localparam int CH_W = 16;
    localparam int CH_IDX_W = 5;
    localparam int CFG_W = 64;
    localparam int CFG_BYTES = 16;
    localparam int CFG_IDX_W = 4;
    localparam int CH_PER_GROUP = 4;
    localparam int IN_W = 64;

    // control and status byte layout
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 3;
    localparam int TOGGLE_BIT = 7;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_LAST_GROUP = 4'h8;
    localparam logic [3:0] SEL_FLAGS = 4'h9;
    localparam logic [2:0] RSVD_VALUE = 3'h0;

    // reset values
    localparam logic [CFG_W-1:0] CFG_RESET = 64'h0000_0000_0000_0000;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'h1,
        SEQ_SCAN = 4'h2,
        SEQ_WAIT = 4'h4,
        SEQ_DONE = 4'h8
    } mtch_seq_t;
endpackage
